// *** src/ixp_expander.sv ***
// Sixteen-line expander: two-wire slave, line config, change interrupt.
// Assumes pins arrive asynchronously and a classic Wishbone master.
`timescale 1ns/1ps
module ixp_expander (
    // Clock and reset.
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RST,
    // Wishbone slave.
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [7:0]  I_WB_ADR,
    input  wire logic [3:0]  I_WB_SEL,
    input  wire logic [31:0] I_WB_DAT,
    output logic      [31:0] O_WB_DAT,
    output logic             O_WB_ACK,
    output logic             O_IRQ,
    // Two-wire link and control pins.
    input  wire logic        I_SCL,
    input  wire logic        I_SDA,
    output logic             O_SDA,
    output logic             O_SDA_OE,
    input  wire logic        I_RESET_N,
    input  wire logic        I_ADDR_SEL,
    output logic             O_INT_N,
    output logic             O_INT_N_OE,
    // Expander lines.
    input  wire logic [15:0] I_IO,
    output logic      [15:0] O_IO,
    output logic      [15:0] O_IO_OE,
    output logic      [15:0] O_IO_PULL_EN,
    output logic      [15:0] O_IO_PULL_UP,
    output logic      [15:0] O_IO_DRIVE
);
    typedef struct packed {
        ixp_pkg::ixp_slv_t            st;
        logic                         scl_d;
        logic                         sda_d;
        logic [7:0]                   sh;
        logic [3:0]                   cnt;
        logic                         rw;
        logic                         mack;
        logic                         first;
        logic [7:0]                   ptr;
        logic [7:0]                   tx;
        logic                         sda_oe;
        logic [15:0]                  out;
        logic [15:0]                  pol;
        logic [15:0]                  dir;
        logic [15:0]                  drive;
        logic [15:0]                  latch;
        logic [15:0]                  pull_en;
        logic [15:0]                  pull_up;
        logic [15:0]                  imask;
        logic [1:0]                   od;
        logic [15:0]                  snap;
        logic [15:0]                  lflag;
        logic [15:0]                  lval;
        logic [1:0]                   fresh;
        logic                         int_oe;
        logic [ixp_pkg::EV_W-1:0]     status;
        logic [ixp_pkg::EV_W-1:0]     mask;
        logic                         ack;
        logic [31:0]                  wbdat;
        logic                         irq;
    } ixp_st_t;

    ixp_st_t     q;
    ixp_st_t     n;
    logic [19:0] sync_q;
    logic        scl_s;
    logic        sda_s;
    logic        rstn_s;
    logic        asel_s;
    logic [15:0] io_s;
    logic [15:0] in_now;
    logic [15:0] in_view;
    logic [15:0] diff;
    logic [15:0] od_mask;
    logic        int_pend;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_c;
    logic        stop_c;
    logic        wb_req;

    // Defaults shared by bus reset and the reset pin.
    function automatic ixp_st_t init_state();
        ixp_st_t s;
        s         = '0;
        s.st      = ixp_pkg::SL_IDLE;
        s.scl_d   = 1'b1;
        s.sda_d   = 1'b1;
        s.out     = ixp_pkg::RST_OUTPUT;
        s.pol     = ixp_pkg::RST_POL;
        s.dir     = ixp_pkg::RST_DIR;
        s.drive   = ixp_pkg::RST_DRIVE;
        s.latch   = ixp_pkg::RST_LATCH;
        s.pull_en = ixp_pkg::RST_PULL_EN;
        s.pull_up = ixp_pkg::RST_PULL_UP;
        s.imask   = ixp_pkg::RST_INT_MASK;
        s.od      = ixp_pkg::RST_OD;
        s.fresh   = ixp_pkg::FRESH_CYC;
        return s;
    endfunction

    // Replace one byte of a word.
    function automatic logic [15:0] put(input logic [15:0] w,
                                        input logic hi,
                                        input logic [7:0] b);
        return hi ? {b, w[7:0]} : {w[15:8], b};
    endfunction

    // Link register read mux, by word index.
    function automatic logic [15:0] rd_word(input logic [6:0] w);
        case (w)
            ixp_pkg::WRD_INPUT:    rd_word = in_view;
            ixp_pkg::WRD_OUTPUT:   rd_word = q.out;
            ixp_pkg::WRD_POL:      rd_word = q.pol;
            ixp_pkg::WRD_DIR:      rd_word = q.dir;
            ixp_pkg::WRD_DRIVE:    rd_word = q.drive;
            ixp_pkg::WRD_LATCH:    rd_word = q.latch;
            ixp_pkg::WRD_PULL_EN:  rd_word = q.pull_en;
            ixp_pkg::WRD_PULL_UP:  rd_word = q.pull_up;
            ixp_pkg::WRD_INT_MASK: rd_word = q.imask;
            ixp_pkg::WRD_OD:       rd_word = {14'h0, q.od};
            ixp_pkg::WRD_INT_STAT: rd_word = diff;
            default:               rd_word = 16'h0000;
        endcase
    endfunction

    // All pins pass two flops; 125 MHz oversamples even the fast rate.
    ixp_sync #(.W(20), .RST_VAL(20'hFFFFF)) u_sync (
        .i_clk (I_REF_CLK),
        .i_rst (I_RST),
        .i_d   ({I_SCL, I_SDA, I_RESET_N, I_ADDR_SEL, I_IO}),
        .o_q   (sync_q)
    );

    // Line view, change detection and link edge detection.
    assign {scl_s, sda_s, rstn_s, asel_s, io_s} = sync_q;
    assign in_now   = io_s ^ q.pol;
    assign in_view  = (q.latch & q.lflag & q.lval)
                    | (~(q.latch & q.lflag) & in_now);
    assign diff     = (in_view ^ q.snap) & q.dir & ~q.imask;
    assign int_pend = |diff;
    assign od_mask  = {{8{q.od[1]}}, {8{q.od[0]}}};
    assign scl_rise = scl_s & ~q.scl_d;
    assign scl_fall = ~scl_s & q.scl_d;
    assign start_c  = scl_s & q.scl_d & q.sda_d & ~sda_s;
    assign stop_c   = scl_s & q.scl_d & ~q.sda_d & sda_s;
    assign wb_req   = I_WB_CYC & I_WB_STB & ~q.ack;

    // Next state of the whole block.
    always_comb begin
        logic [15:0]               bm;
        logic [15:0]               lset;
        logic [ixp_pkg::EV_W-1:0]  ev;
        logic [ixp_pkg::EV_W-1:0]  clr;
        logic                      load;
        logic [15:0]               rd_val;
        bm      = q.ptr[0] ? 16'hFF00 : 16'h00FF;
        lset    = q.latch & ~q.lflag & (in_now ^ q.snap);
        ev      = '0;
        clr     = '0;
        load    = 1'b0;
        rd_val  = rd_word(q.ptr[7:1]);
        n       = q;
        n.scl_d = scl_s;
        n.sda_d = sda_s;
        n.ack   = wb_req;
        // Link slave; bits are taken on rise, SDA moves only on fall.
        if (start_c) begin
            n.st     = ixp_pkg::SL_ADDR;
            n.cnt    = 4'h0;
            n.sda_oe = 1'b0;
        end else if (stop_c) begin
            n.st     = ixp_pkg::SL_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            case (q.st)
                ixp_pkg::SL_ADDR, ixp_pkg::SL_WRITE: begin
                    if (scl_rise) begin
                        n.sh  = {q.sh[6:0], sda_s};
                        n.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == ixp_pkg::BITS_BYTE) begin
                        n.cnt = 4'h0;
                        if (q.st == ixp_pkg::SL_WRITE) begin
                            n.sda_oe = 1'b1;
                            n.st     = ixp_pkg::SL_ACK_W;
                            n.first  = 1'b0;
                            ev[ixp_pkg::EV_WRITE] = 1'b1;
                            if (q.first) begin
                                n.ptr = q.sh;
                            end else begin
                                n.ptr = (q.ptr == ixp_pkg::PTR_LAST) ?
                                        8'h00 : q.ptr + 8'h01;
                                case (q.ptr[7:1])
                                    ixp_pkg::WRD_OUTPUT:   n.out     = put(q.out, q.ptr[0], q.sh);
                                    ixp_pkg::WRD_POL:      n.pol     = put(q.pol, q.ptr[0], q.sh);
                                    ixp_pkg::WRD_DIR:      n.dir     = put(q.dir, q.ptr[0], q.sh);
                                    ixp_pkg::WRD_DRIVE:    n.drive   = put(q.drive, q.ptr[0], q.sh);
                                    ixp_pkg::WRD_LATCH:    n.latch   = put(q.latch, q.ptr[0], q.sh);
                                    ixp_pkg::WRD_PULL_EN:  n.pull_en = put(q.pull_en, q.ptr[0], q.sh);
                                    ixp_pkg::WRD_PULL_UP:  n.pull_up = put(q.pull_up, q.ptr[0], q.sh);
                                    ixp_pkg::WRD_INT_MASK: n.imask   = put(q.imask, q.ptr[0], q.sh);
                                    ixp_pkg::WRD_OD: begin
                                        if (!q.ptr[0]) begin
                                            n.od = q.sh[1:0];
                                        end
                                    end
                                    default: begin
                                    end
                                endcase
                            end
                        end else if (q.sh[7:1] == {ixp_pkg::SLV_ADDR_HI,
                                                  asel_s}) begin
                            n.sda_oe = 1'b1;
                            n.rw     = q.sh[0];
                            n.st     = ixp_pkg::SL_ACK_A;
                        end else begin
                            n.st = ixp_pkg::SL_IDLE;
                        end
                    end
                end
                ixp_pkg::SL_ACK_A: begin
                    if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        n.first  = 1'b1;
                        n.st     = ixp_pkg::SL_WRITE;
                        load     = q.rw;
                    end
                end
                ixp_pkg::SL_ACK_W: begin
                    if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        n.st     = ixp_pkg::SL_WRITE;
                    end
                end
                ixp_pkg::SL_READ: begin
                    if (scl_rise) begin
                        n.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == ixp_pkg::BITS_BYTE) begin
                        n.sda_oe = 1'b0;
                        n.cnt    = 4'h0;
                        n.st     = ixp_pkg::SL_ACK_M;
                    end else if (scl_fall) begin
                        n.tx     = {q.tx[6:0], 1'b0};
                        n.sda_oe = ~q.tx[6];
                    end
                end
                ixp_pkg::SL_ACK_M: begin
                    if (scl_rise) begin
                        n.mack = ~sda_s;
                        if (!sda_s) begin
                            n.ptr = (q.ptr == ixp_pkg::PTR_LAST) ?
                                    8'h00 : q.ptr + 8'h01;
                        end
                    end else if (scl_fall) begin
                        load = q.mack;
                        n.st = q.mack ? ixp_pkg::SL_READ : ixp_pkg::SL_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end
        // Loading a byte for the master; an input read re-arms the change.
        if (load) begin
            n.tx     = q.ptr[0] ? rd_val[15:8] : rd_val[7:0];
            n.sda_oe = q.ptr[0] ? ~rd_val[15] : ~rd_val[7];
            n.st     = ixp_pkg::SL_READ;
            n.cnt    = 4'h0;
            ev[ixp_pkg::EV_READ] = 1'b1;
            if (q.ptr[7:1] == ixp_pkg::WRD_INPUT) begin
                n.snap  = (q.snap & ~bm) | (in_view & bm);
                n.lflag = q.lflag & ~bm;
            end
        end
        // Latch capture is applied after the read clear, so a new change wins.
        n.lflag = n.lflag | lset;
        n.lval  = (q.lval & ~lset) | (in_now & lset);
        // The snapshot follows the lines while the synchronisers settle.
        if (q.fresh != 2'h0) begin
            n.fresh = q.fresh - 2'h1;
            n.snap  = in_now;
        end
        // Open-drain interrupt pulls low while a difference stands.
        n.int_oe = int_pend & (q.fresh == 2'h0);
        ev[ixp_pkg::EV_CHANGE] = n.int_oe & ~q.int_oe;
        // Wishbone access; the answer comes one cycle after the request.
        if (wb_req) begin
            n.wbdat = 32'h0000_0000;
            if (I_WB_WE) begin
                if (I_WB_ADR == ixp_pkg::WB_MASK && I_WB_SEL[0]) begin
                    n.mask = I_WB_DAT[ixp_pkg::EV_W-1:0];
                end
            end else begin
                case (I_WB_ADR)
                    ixp_pkg::WB_STATUS: begin
                        n.wbdat[ixp_pkg::EV_W-1:0] = q.status;
                        clr = '1;
                    end
                    ixp_pkg::WB_MASK: n.wbdat[ixp_pkg::EV_W-1:0] = q.mask;
                    ixp_pkg::WB_PINS: n.wbdat = {in_now, q.out};
                    default: n.wbdat = 32'h0000_0000;
                endcase
            end
        end
        // A fresh event beats the clear-on-read of the same cycle.
        n.status = (q.status & ~clr) | ev;
        n.irq    = |(n.status & n.mask);
        // The reset pin restores every default and restarts the slave.
        if (!rstn_s) begin
            n = init_state();
        end
    end

    // State register.
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            q <= init_state();
        end else begin
            q <= n;
        end
    end

    // Outputs; open-drain lines only ever pull low.
    assign O_WB_DAT     = q.wbdat;
    assign O_WB_ACK     = q.ack;
    assign O_IRQ        = q.irq;
    assign O_SDA        = 1'b0;
    assign O_SDA_OE     = q.sda_oe;
    assign O_INT_N      = 1'b0;
    assign O_INT_N_OE   = q.int_oe;
    assign O_IO         = q.out;
    assign O_IO_OE      = ~q.dir & ~(od_mask & q.out);
    assign O_IO_PULL_EN = q.pull_en;
    assign O_IO_PULL_UP = q.pull_up;
    assign O_IO_DRIVE   = q.drive;

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);

    sequence pend_two;
        int_pend && q.fresh == 2'h0 ##1 int_pend;
    endsequence
    sequence quiet_two;
        !int_pend ##1 !int_pend;
    endsequence

    sda_on_low_a: assert property (
        $changed(q.sda_oe) && $past(rstn_s) && !$past(start_c)
            && !$past(stop_c) |-> !$past(scl_s))
        else $error("SDA driver moved while SCL was high");
    pin_reset_a: assert property (
        !rstn_s |=> q.st == ixp_pkg::SL_IDLE && q.dir == ixp_pkg::RST_DIR
            && !O_SDA_OE && q.out == ixp_pkg::RST_OUTPUT)
        else $error("Reset pin did not restore defaults");
    addr_match_a: assert property (
        q.st == ixp_pkg::SL_ACK_A && $past(q.st) == ixp_pkg::SL_ADDR
            |-> $past(q.sh[7:1]) == {ixp_pkg::SLV_ADDR_HI, $past(asel_s)}
                && O_SDA_OE)
        else $error("Acknowledged a foreign address");
    int_raise_a: assert property (
        pend_two |-> O_INT_N_OE)
        else $error("Input change left interrupt released");
    out_dir_a: assert property (
        (O_IO_OE & q.dir) == 16'h0000)
        else $error("An input line is being driven");
    cfg_write_a: assert property (
        $changed(q.dir) |-> $past(q.st) == ixp_pkg::SL_WRITE
            || !$past(rstn_s))
        else $error("Direction changed without a link write");
    int_release_a: assert property (
        quiet_two |-> !O_INT_N_OE)
        else $error("Interrupt held without a difference");
    wb_ack_a: assert property (
        wb_req |=> O_WB_ACK ##1 !O_WB_ACK)
        else $error("Wishbone answer not a single cycle");
endmodule

// *** shared/ixp_pkg.sv ***
// Constants and types shared by the sixteen-line expander design.
// Assumes a 125 MHz system clock and a two-wire link sampled by it.
package ixp_pkg;

    // Two-wire slave address: six fixed bits, the select pin is the last.
    localparam logic [5:0] SLV_ADDR_HI = 6'h10;

    // Link register map: pointer bit 0 picks the byte, the rest the word.
    localparam logic [6:0] WRD_INPUT    = 7'h00;
    localparam logic [6:0] WRD_OUTPUT   = 7'h01;
    localparam logic [6:0] WRD_POL      = 7'h02;
    localparam logic [6:0] WRD_DIR      = 7'h03;
    localparam logic [6:0] WRD_DRIVE    = 7'h04;
    localparam logic [6:0] WRD_LATCH    = 7'h05;
    localparam logic [6:0] WRD_PULL_EN  = 7'h06;
    localparam logic [6:0] WRD_PULL_UP  = 7'h07;
    localparam logic [6:0] WRD_INT_MASK = 7'h08;
    localparam logic [6:0] WRD_OD       = 7'h09;
    localparam logic [6:0] WRD_INT_STAT = 7'h0A;
    localparam logic [7:0] PTR_LAST     = 8'h15;

    // Default values restored by either reset; BITS_BYTE is the bit count of a byte.
    localparam logic [15:0] RST_OUTPUT   = 16'hFFFF;
    localparam logic [15:0] RST_POL      = 16'h0000;
    localparam logic [15:0] RST_DIR      = 16'hFFFF;
    localparam logic [15:0] RST_DRIVE    = 16'hFFFF;
    localparam logic [15:0] RST_LATCH    = 16'h0000;
    localparam logic [15:0] RST_PULL_EN  = 16'h0000;
    localparam logic [15:0] RST_PULL_UP  = 16'hFFFF;
    localparam logic [15:0] RST_INT_MASK = 16'hFFFF;
    localparam logic [1:0]  RST_OD       = 2'h0;
    localparam logic [1:0]  FRESH_CYC    = 2'h3;
    localparam logic [3:0]  BITS_BYTE    = 4'h8;

    // Wishbone map, byte addresses of aligned words.
    localparam logic [7:0] WB_STATUS = 8'h00;
    localparam logic [7:0] WB_MASK   = 8'h04;
    localparam logic [7:0] WB_PINS   = 8'h08;

    // Event bits of the status and mask registers.
    localparam int EV_CHANGE = 0;
    localparam int EV_WRITE  = 1;
    localparam int EV_READ   = 2;
    localparam int EV_W      = 3;

    // Link slave states.
    typedef enum logic [2:0] {
        SL_IDLE, SL_ADDR, SL_ACK_A, SL_WRITE, SL_ACK_W, SL_READ, SL_ACK_M
    } ixp_slv_t;

endpackage

// *** src/ixp_sync.sv ***
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes the pins are static long enough to be sampled twice.
`timescale 1ns/1ps
module ixp_sync #(
    parameter int            W       = 1,
    parameter logic [W-1:0]  RST_VAL = '1
) (
    // Clock and reset.
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // Pins in, settled copy out.
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ixp_sync_st_t;

    ixp_sync_st_t q;
    ixp_sync_st_t n;

    // The first stage feeds only the second, so metastability stays inside.
    always_comb begin
        n    = q;
        n.s1 = i_d;
        n.s2 = q.s1;
    end

    // State register.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q <= {RST_VAL, RST_VAL};
        end else begin
            q <= n;
        end
    end

    assign o_q = q.s2;
endmodule

// *** testbench/ixp_host.sv ***
// Host model: a two-wire bus master that drives clock and data.
// Assumes an open-drain data wire with a pull-up, resolved by the bench.
`timescale 1ns/1ps
module ixp_host (
    // Link wires.
    output logic      scl,
    output logic      sda_oe,
    input  wire logic sda
);
    // Half of the 160 ns link period; the slave samples it, so any slower rate works.
    localparam time H = 80;

    // The clock stands high and data is released outside frames.
    initial begin
        scl    = 1'b1;
        sda_oe = 1'b0;
    end

    // One bit: data moves in mid low phase, sampled in mid high phase.
    task automatic bit_x(input logic b, output logic s);
        scl = 1'b0;
        #(H/2) sda_oe = ~b;
        #(H/2) scl = 1'b1;
        #(H/2) s = sda;
        #(H/2);
    endtask

    // Start, also usable as a repeated start.
    task automatic start;
        scl = 1'b0;
        #(H/2) sda_oe = 1'b0;
        #(H/2) scl = 1'b1;
        #(H/2) sda_oe = 1'b1;
        #(H/2);
    endtask

    task automatic stop;
        scl = 1'b0;
        #(H/2) sda_oe = 1'b1;
        #(H/2) scl = 1'b1;
        #(H/2) sda_oe = 1'b0;
        #(H/2);
    endtask

    // Eight bits most significant first, then the answer bit.
    task automatic byte_x(input logic [7:0] d, input logic n,
                          output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
        bit_x(n, a);
    endtask

    // Whole transfer; the address bit follows the sel input of the task.
    task automatic xfer(input logic sel, input logic [7:0] p,
                        input logic rd, input logic [7:0] wd,
                        output logic [7:0] rq, output logic ok);
        logic [7:0] q;
        logic       a0, a1, a2, d;
        start;
        byte_x({ixp_pkg::SLV_ADDR_HI, sel, 1'b0}, 1'b1, q, a0);
        byte_x(p, 1'b1, q, a1);
        if (rd) begin
            start;
            byte_x({ixp_pkg::SLV_ADDR_HI, sel, 1'b1}, 1'b1, q, a2);
            byte_x(8'hFF, 1'b1, rq, d);
        end else begin
            byte_x(wd, 1'b1, rq, a2);
        end
        stop;
        ok = ~(a0 | a1 | a2);
    endtask
endmodule

// *** testbench/tb_i2c_sixteen_bit_io_expander.sv ***
// Self-checking bench: Wishbone tasks plus a two-wire host model.
// Assumes the link wires are open drain with pull-ups.
`timescale 1ns/1ps
module tb_i2c_sixteen_bit_io_expander;
    logic        clk, rst, cyc, stb, we, reset_n, addr_sel, ok, ack, irq;
    logic        sda_o, sda_oe, int_n_o, int_oe, scl, h_oe;
    logic [7:0]  adr, b;
    logic [31:0] wdat, rdat, q;
    logic [15:0] io_in, io_o, io_oe, pen, pup, drv;
    int          error_cnt, comparisons, cyc_cnt;
    wire logic   sda   = ~(sda_oe | h_oe);
    wire logic   int_n = ~int_oe;

    ixp_host HOST (.scl(scl), .sda_oe(h_oe), .sda(sda));

    ixp_expander DUT (
        .I_REF_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat),
        .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_IRQ(irq), .I_SCL(scl),
        .I_SDA(sda), .O_SDA(sda_o), .O_SDA_OE(sda_oe),
        .I_RESET_N(reset_n), .I_ADDR_SEL(addr_sel), .O_INT_N(int_n_o),
        .O_INT_N_OE(int_oe), .I_IO(io_in), .O_IO(io_o), .O_IO_OE(io_oe),
        .O_IO_PULL_EN(pen), .O_IO_PULL_UP(pup), .O_IO_DRIVE(drv));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic conclude;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // A hung handshake must not stall the run forever.
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 60000) begin
            error_cnt++;
            conclude;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic cycle: held until the rising edge that sees ack, taken there.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0; stb <= 1'b0;
    endtask

    task automatic lw(input logic [7:0] p, input logic [7:0] d);
        logic [7:0] r;
        logic       k;
        HOST.xfer(addr_sel, p, 1'b0, d, r, k);
        chk(k, 1);
        repeat (4) @(posedge clk);
    endtask

    task automatic lr(input logic [7:0] p, output logic [7:0] r);
        logic k;
        HOST.xfer(addr_sel, p, 1'b1, 8'h00, r, k);
        chk(k, 1);
        repeat (4) @(posedge clk);
    endtask

    task automatic setin(input logic [15:0] v);
        @(posedge clk);
        io_in <= v;
        repeat (20) @(posedge clk);
    endtask

    initial begin
        rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
        wdat = 32'h0; reset_n = 1'b1; addr_sel = 1'b0; io_in = 16'h0000;
        error_cnt = 0; comparisons = 0; cyc_cnt = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        chk(io_o, 16'hFFFF);
        chk(io_oe, 16'h0000);
        wb(1'b0, ixp_pkg::WB_PINS, 32'h0, q);
        chk(q[15:0], 16'hFFFF);
        // Board setup: low byte drives, high byte senses.
        lw(8'h06, 8'h00);
        lw(8'h07, 8'hFF);
        lw(8'h02, 8'hA5);
        chk(io_o[7:0], 8'hA5);
        chk(io_oe, 16'h00FF);
        lw(8'h0C, 8'h3C);
        chk(pen[7:0], 8'h3C);
        lw(8'h0E, 8'h0F);
        chk(pup[7:0], 8'h0F);
        lw(8'h08, 8'h55);
        chk(drv[7:0], 8'h55);
        // Open drain only sinks, so high outputs stop driving.
        lw(8'h12, 8'h01);
        chk(io_oe, 16'h005A);
        lw(8'h12, 8'h00);
        setin(16'h5A00);
        lr(8'h01, b);
        chk(b, 8'h5A);
        lw(8'h05, 8'hFF);
        lr(8'h01, b);
        chk(b, 8'hA5);
        lw(8'h05, 8'h00);
        // The other address answers only with the select pin high.
        @(posedge clk);
        addr_sel <= 1'b1;
        HOST.xfer(1'b0, 8'h02, 1'b0, 8'h11, b, ok);
        chk(ok, 0);
        lw(8'h02, 8'h3C);
        chk(io_o[7:0], 8'h3C);
        // Change interrupt, unmasked, raised and cleared.
        lw(8'h11, 8'h00);
        lr(8'h01, b);
        wb(1'b1, ixp_pkg::WB_MASK, 32'h1, q);
        wb(1'b0, ixp_pkg::WB_STATUS, 32'h0, q);
        chk(irq, 0);
        setin(16'h5B00);
        chk(int_n, 0);
        chk(irq, 1);
        wb(1'b0, ixp_pkg::WB_STATUS, 32'h0, q);
        chk(q, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        lr(8'h01, b);
        chk(int_n, 1);
        setin(16'h5900);
        chk(int_n, 0);
        setin(16'h5B00);
        chk(int_n, 1);
        // A latched line keeps its changed level until its byte is read.
        lw(8'h0B, 8'h01);
        setin(16'h5A00);
        setin(16'h5B00);
        chk(int_n, 0);
        lr(8'h01, b);
        chk(b, 8'h5A);
        lr(8'h01, b);
        chk(b, 8'h5B);
        chk(int_n, 1);
        lw(8'h0B, 8'h00);
        // Read-only and unmapped places; events since the last read stand.
        wb(1'b0, ixp_pkg::WB_STATUS, 32'h0, q);
        chk(q, 32'h7);
        wb(1'b1, ixp_pkg::WB_STATUS, 32'h7, q);
        wb(1'b0, ixp_pkg::WB_STATUS, 32'h0, q);
        chk(q, 32'h0);
        wb(1'b0, 8'h0C, 32'h0, q);
        chk(q, 32'h0);
        // Host recovery pulse on the reset pin.
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk(io_o, 16'hFFFF);
        chk(io_oe, 16'h0000);
        wb(1'b0, ixp_pkg::WB_MASK, 32'h0, q);
        chk(q, 32'h0);
        lw(8'h02, 8'h00);
        chk(io_o, 16'hFF00);
        conclude;
    end
endmodule
